//--- rtl/dsec_pkg.sv
// Constants and types for the debug state entry control block
package dsec_pkg;

    // ****************************************************************
    // Widths and synchroniser stage count
    // ****************************************************************
    localparam int MODE_W = 5;
    localparam int INSTR_W = 32;
    localparam int SYNC_STAGES = 2;

    // ****************************************************************
    // Transfer type forced while in debug state (internal cycle)
    // ****************************************************************
    localparam logic [1:0] HTRANS_INTERNAL = 2'h0;

    // ****************************************************************
    // Abort source codes
    // ****************************************************************
    localparam logic [1:0] ABORT_SRC_MEMORY = 2'h0;
    localparam logic [1:0] ABORT_SRC_BREAK = 2'h1;
    localparam logic [1:0] ABORT_SRC_WATCH = 2'h2;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [1:0] RESET_ABORT_SRC = 2'h0;
    localparam logic [MODE_W-1:0] RESET_MODE = 5'h00;
    localparam logic [INSTR_W-1:0] RESET_INSTR = 32'h0000_0000;

    // ****************************************************************
    // Control states
    // ****************************************************************
    typedef enum logic [1:0] {
        DSEC_RUN = 2'b00,
        DSEC_DEBUG = 2'b01,
        DSEC_EXIT = 2'b10
    } dsec_state_type;

endpackage

//--- rtl/dsec_sync.sv
// Two flip-flop level synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dsec_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end

endmodule
`default_nettype wire

//--- rtl/dsec_bp_tag.sv
// Breakpoint tag pipeline: fetch, decode and execute slots
`timescale 1ns/10ps
`default_nettype none
module dsec_bp_tag (
    input wire logic clk,
    input wire logic resetn,
    input wire logic advance,
    input wire logic flush,
    input wire logic fetch_tag,
    input wire logic late_tag,
    output logic exec_tag
);

    // ****************************************************************
    // Tag slots
    // ****************************************************************
    logic fetch_slot;
    logic decode_slot;
    logic next_fetch_slot;
    logic next_decode_slot;
    logic next_exec_tag;

    always_comb begin
        next_fetch_slot = fetch_slot | fetch_tag;
        next_decode_slot = decode_slot | late_tag;
        next_exec_tag = exec_tag;
        if (flush) begin
            // Flushed instructions lose their flag
            next_fetch_slot = 1'b0;
            next_decode_slot = 1'b0;
            next_exec_tag = 1'b0;
        end else if (advance) begin
            // Flag travels with its instruction
            next_fetch_slot = fetch_tag;
            next_decode_slot = fetch_slot;
            next_exec_tag = decode_slot | late_tag;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fetch_slot <= 1'b0;
            decode_slot <= 1'b0;
            exec_tag <= 1'b0;
        end else begin
            fetch_slot <= next_fetch_slot;
            decode_slot <= next_decode_slot;
            exec_tag <= next_exec_tag;
        end
    end

endmodule
`default_nettype wire

//--- rtl/dsec_top.sv
// Debug state entry control: halt and monitor handling of debug events
`timescale 1ns/10ps
`default_nettype none
module dsec_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic halt_mode_cfg,
    input wire logic external_break_flag,
    input wire logic external_debug_request,
    input wire logic fetch_valid,
    input wire logic fetch_bp_hit,
    input wire logic data_valid,
    input wire logic data_wp_hit,
    input wire logic pipe_advance,
    input wire logic flush_branch,
    input wire logic flush_exception,
    input wire logic exec_valid,
    input wire logic instr_complete,
    input wire logic cp_busy_wait,
    input wire logic mem_abort,
    input wire logic exception_pending,
    input wire logic [dsec_pkg::MODE_W-1:0] exception_mode,
    input wire logic [dsec_pkg::MODE_W-1:0] current_mode,
    input wire logic irq_in,
    input wire logic [1:0] core_htrans,
    input wire logic scan_instr_valid,
    input wire logic [dsec_pkg::INSTR_W-1:0] scan_instr,
    input wire logic debug_restart,
    output logic debug_state_ack,
    output logic core_halt,
    output logic exec_cancel,
    output logic instr_abort,
    output logic data_abort,
    output logic [1:0] abort_source,
    output logic block_updates,
    output logic cp_terminate,
    output logic refetch_req,
    output logic [dsec_pkg::MODE_W-1:0] debug_entry_mode,
    output logic [1:0] htrans,
    output logic irq_out,
    output logic abort_out,
    output logic inject_valid,
    output logic [dsec_pkg::INSTR_W-1:0] inject_instr
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic break_sync;
    logic request_sync;

    dsec_sync u_break_sync (
        .clk(clk),
        .resetn(resetn),
        .din(external_break_flag),
        .dout(break_sync)
    );

    dsec_sync u_request_sync (
        .clk(clk),
        .resetn(resetn),
        .din(external_debug_request),
        .dout(request_sync)
    );

    // ****************************************************************
    // Strobe alignment with the synchronised break flag
    // ****************************************************************
    logic [dsec_pkg::SYNC_STAGES-1:0] fetch_dly;
    logic [dsec_pkg::SYNC_STAGES-1:0] data_dly;
    logic [dsec_pkg::SYNC_STAGES-1:0] next_fetch_dly;
    logic [dsec_pkg::SYNC_STAGES-1:0] next_data_dly;
    logic ext_bp;
    logic ext_wp;

    always_comb begin
        next_fetch_dly = {fetch_dly[0], fetch_valid};
        next_data_dly = {data_dly[0], data_valid};
        // External flag pairs with its fetch or data edge
        ext_bp = fetch_dly[dsec_pkg::SYNC_STAGES-1] & break_sync;
        ext_wp = data_dly[dsec_pkg::SYNC_STAGES-1] & break_sync;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fetch_dly <= '0;
            data_dly <= '0;
        end else begin
            fetch_dly <= next_fetch_dly;
            data_dly <= next_data_dly;
        end
    end

    // ****************************************************************
    // Breakpoint tag pipeline
    // ****************************************************************
    logic exec_tag;
    logic pipe_flush;

    always_comb begin
        pipe_flush = flush_branch | flush_exception;
    end

    dsec_bp_tag u_bp_tag (
        .clk(clk),
        .resetn(resetn),
        .advance(pipe_advance),
        .flush(pipe_flush),
        .fetch_tag(fetch_valid & fetch_bp_hit),
        .late_tag(ext_bp),
        .exec_tag(exec_tag)
    );

    // ****************************************************************
    // Entry control
    // ****************************************************************
    dsec_pkg::dsec_state_type state;
    dsec_pkg::dsec_state_type next_state;
    logic wp_pend;
    logic rq_pend;
    logic mode_lock;
    logic locked_halt;
    logic next_wp_pend;
    logic next_rq_pend;
    logic next_mode_lock;
    logic next_locked_halt;
    logic next_debug_state_ack;
    logic next_core_halt;
    logic next_exec_cancel;
    logic next_instr_abort;
    logic next_data_abort;
    logic [1:0] next_abort_source;
    logic next_block_updates;
    logic next_cp_terminate;
    logic next_refetch_req;
    logic [dsec_pkg::MODE_W-1:0] next_debug_entry_mode;
    logic [1:0] next_htrans;
    logic next_irq_out;
    logic next_abort_out;
    logic next_inject_valid;
    logic [dsec_pkg::INSTR_W-1:0] next_inject_instr;
    logic eff_halt;
    logic bp_exec;
    logic wp_new;
    logic enter;

    always_comb begin
        next_state = state;
        next_wp_pend = wp_pend;
        next_rq_pend = rq_pend;
        next_mode_lock = mode_lock;
        next_locked_halt = locked_halt;
        next_exec_cancel = 1'b0;
        next_instr_abort = 1'b0;
        next_data_abort = 1'b0;
        next_abort_source = abort_source;
        next_block_updates = 1'b0;
        next_cp_terminate = 1'b0;
        next_refetch_req = 1'b0;
        next_debug_entry_mode = debug_entry_mode;
        next_inject_valid = 1'b0;
        next_inject_instr = inject_instr;
        enter = 1'b0;
        // Mode held fixed while a watchpoint is pending
        eff_halt = mode_lock ? locked_halt : halt_mode_cfg;
        // Condition not looked at
        bp_exec = exec_tag & exec_valid & ~pipe_flush;
        wp_new = (data_valid & data_wp_hit) | ext_wp;
        case (state)
            dsec_pkg::DSEC_RUN: begin
                if (wp_new && !wp_pend) begin
                    next_wp_pend = 1'b1;
                    next_mode_lock = 1'b1;
                    next_locked_halt = eff_halt;
                end
                if (request_sync && halt_mode_cfg) begin
                    next_rq_pend = 1'b1;
                end
                if (bp_exec) begin
                    // Cancelled, state stays before it
                    next_exec_cancel = 1'b1;
                    if (eff_halt) begin
                        enter = 1'b1;
                        next_debug_entry_mode = current_mode;
                    end else begin
                        next_instr_abort = 1'b1;
                        next_abort_source = dsec_pkg::ABORT_SRC_BREAK;
                    end
                end else if ((wp_pend || wp_new) && instr_complete) begin
                    // Taken once the instruction finishes
                    next_wp_pend = 1'b0;
                    next_mode_lock = 1'b0;
                    if (wp_pend ? locked_halt : eff_halt) begin
                        enter = 1'b1;
                        // Pending exception mode used
                        next_debug_entry_mode = exception_pending ?
                            exception_mode : current_mode;
                    end else begin
                        // Abort taken, core keeps running
                        next_data_abort = 1'b1;
                        next_abort_source = dsec_pkg::ABORT_SRC_WATCH;
                    end
                end else if ((rq_pend || (request_sync && halt_mode_cfg)) &&
                             (instr_complete || cp_busy_wait)) begin
                    // Busy coprocessor wait ends at once
                    next_cp_terminate = cp_busy_wait & ~instr_complete;
                    enter = 1'b1;
                    next_debug_entry_mode = exception_pending ?
                        exception_mode : current_mode;
                end else if (mem_abort) begin
                    // Genuine abort freezes later state changes
                    next_block_updates = 1'b1;
                    next_abort_source = dsec_pkg::ABORT_SRC_MEMORY;
                end
                if (enter) begin
                    next_state = dsec_pkg::DSEC_DEBUG;
                    next_rq_pend = 1'b0;
                    next_wp_pend = 1'b0;
                    next_mode_lock = 1'b0;
                end
            end
            dsec_pkg::DSEC_DEBUG: begin
                // Serial instructions go to the pipeline
                next_inject_valid = scan_instr_valid;
                if (scan_instr_valid) begin
                    next_inject_instr = scan_instr;
                end
                if (debug_restart) begin
                    next_state = dsec_pkg::DSEC_EXIT;
                end
            end
            dsec_pkg::DSEC_EXIT: begin
                // Resume by refetching the stopped instruction
                next_refetch_req = 1'b1;
                next_state = dsec_pkg::DSEC_RUN;
            end
            default: begin
                next_state = dsec_pkg::DSEC_RUN;
            end
        endcase
        // Acknowledge on entry
        next_debug_state_ack = (next_state == dsec_pkg::DSEC_DEBUG);
        next_core_halt = next_debug_state_ack;
        // Only internal cycles and no events in debug state
        next_htrans = next_debug_state_ack ?
            dsec_pkg::HTRANS_INTERNAL : core_htrans;
        next_irq_out = irq_in & ~next_debug_state_ack;
        next_abort_out = mem_abort & ~next_debug_state_ack;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= dsec_pkg::DSEC_RUN;
            wp_pend <= 1'b0;
            rq_pend <= 1'b0;
            mode_lock <= 1'b0;
            locked_halt <= 1'b0;
            debug_state_ack <= 1'b0;
            core_halt <= 1'b0;
            exec_cancel <= 1'b0;
            instr_abort <= 1'b0;
            data_abort <= 1'b0;
            abort_source <= dsec_pkg::RESET_ABORT_SRC;
            block_updates <= 1'b0;
            cp_terminate <= 1'b0;
            refetch_req <= 1'b0;
            debug_entry_mode <= dsec_pkg::RESET_MODE;
            htrans <= dsec_pkg::HTRANS_INTERNAL;
            irq_out <= 1'b0;
            abort_out <= 1'b0;
            inject_valid <= 1'b0;
            inject_instr <= dsec_pkg::RESET_INSTR;
        end else begin
            state <= next_state;
            wp_pend <= next_wp_pend;
            rq_pend <= next_rq_pend;
            mode_lock <= next_mode_lock;
            locked_halt <= next_locked_halt;
            debug_state_ack <= next_debug_state_ack;
            core_halt <= next_core_halt;
            exec_cancel <= next_exec_cancel;
            instr_abort <= next_instr_abort;
            data_abort <= next_data_abort;
            abort_source <= next_abort_source;
            block_updates <= next_block_updates;
            cp_terminate <= next_cp_terminate;
            refetch_req <= next_refetch_req;
            debug_entry_mode <= next_debug_entry_mode;
            htrans <= next_htrans;
            irq_out <= next_irq_out;
            abort_out <= next_abort_out;
            inject_valid <= next_inject_valid;
            inject_instr <= next_inject_instr;
        end
    end

endmodule
`default_nettype wire

//--- test/dsec_top_assertions.sv
// Port checks for the debug state entry control block
`timescale 1ns/10ps
`default_nettype none
module dsec_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic exception_pending,
    input wire logic [dsec_pkg::MODE_W-1:0] exception_mode,
    input wire logic [dsec_pkg::MODE_W-1:0] current_mode,
    input wire logic [1:0] core_htrans,
    input wire logic mem_abort,
    input wire logic debug_restart,
    input wire logic debug_state_ack,
    input wire logic core_halt,
    input wire logic exec_cancel,
    input wire logic instr_abort,
    input wire logic data_abort,
    input wire logic [1:0] abort_source,
    input wire logic block_updates,
    input wire logic refetch_req,
    input wire logic [dsec_pkg::MODE_W-1:0] debug_entry_mode,
    input wire logic [1:0] htrans,
    input wire logic irq_out,
    input wire logic abort_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ****************************************************************
    // Exit steps
    // ****************************************************************
    sequence s_restart;
        debug_state_ack && debug_restart;
    endsequence
    sequence s_leave;
        !debug_state_ack ##1 refetch_req ##1 !refetch_req;
    endsequence
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_halt_ack_same: assert property (core_halt == debug_state_ack)
        else $error("halt and acknowledge differ");
    a_ack_holds: assert property (debug_state_ack && !debug_restart |=> debug_state_ack)
        else $error("left debug early");
    a_debug_htrans: assert property (debug_state_ack |-> htrans == dsec_pkg::HTRANS_INTERNAL)
        else $error("transfer not internal");
    a_events_masked: assert property (debug_state_ack |-> !irq_out && !abort_out)
        else $error("event passed in debug state");
    a_htrans_follow: assert property ($past(resetn) && !debug_state_ack && !refetch_req && !$past(refetch_req) |-> htrans == $past(core_htrans))
        else $error("transfer not passed");
    a_leave_debug: assert property (s_restart |=> s_leave)
        else $error("restart did not refetch");
    a_cancel_cause: assert property (exec_cancel |-> debug_state_ack || instr_abort)
        else $error("cancel without entry or abort");
    a_break_source: assert property (instr_abort |-> abort_source == dsec_pkg::ABORT_SRC_BREAK && !debug_state_ack)
        else $error("break source wrong");
    a_watch_source: assert property (data_abort |-> abort_source == dsec_pkg::ABORT_SRC_WATCH && !debug_state_ack)
        else $error("data abort source wrong");
    a_block_cause: assert property (block_updates |-> $past(mem_abort))
        else $error("update block without abort");
    a_entry_mode: assert property ($rose(debug_state_ack) |-> debug_entry_mode == ($past(exception_pending) ? $past(exception_mode) : $past(current_mode)))
        else $error("entry mode wrong");
    c_entry: cover property ($rose(debug_state_ack));
endmodule
bind dsec_top dsec_checker u_checker (.clk(clk), .resetn(resetn),
    .exception_pending(exception_pending), .exception_mode(exception_mode),
    .current_mode(current_mode), .core_htrans(core_htrans),
    .mem_abort(mem_abort), .debug_restart(debug_restart),
    .debug_state_ack(debug_state_ack), .core_halt(core_halt),
    .exec_cancel(exec_cancel), .instr_abort(instr_abort),
    .data_abort(data_abort), .abort_source(abort_source),
    .block_updates(block_updates), .refetch_req(refetch_req),
    .debug_entry_mode(debug_entry_mode), .htrans(htrans),
    .irq_out(irq_out), .abort_out(abort_out));
`default_nettype wire

//--- test/dsec_break_agent.sv
// External break flagging logic and debug requester model
`timescale 1ns/10ps
`default_nettype none
module dsec_break_agent (
    input wire logic clk,
    input wire logic resetn,
    input wire logic fetch_valid,
    input wire logic data_valid,
    input wire logic flag_fetch,
    input wire logic flag_data,
    input wire logic req_go,
    input wire logic debug_state_ack,
    output logic external_break_flag,
    output logic external_debug_request
);
    logic req;
    logic req_done;
    // Flag stands over the sampling edge
    assign external_break_flag = (fetch_valid && flag_fetch)
        || (data_valid && flag_data);
    // Request drops with acknowledge
    assign external_debug_request = req && !debug_state_ack;
    always_ff @(posedge clk) begin
        if (!resetn || !req_go) begin
            req <= 1'b0;
            req_done <= 1'b0;
        end else if (debug_state_ack) begin
            req <= 1'b0;
            req_done <= 1'b1;
        end else if (!req_done) begin
            req <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the debug state entry control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [11:0] FV = 12'h001, BP = 12'h002, DV = 12'h004,
        WP = 12'h008, ADV = 12'h010, FB = 12'h020, FE = 12'h040,
        IC = 12'h080, RS = 12'h100, SV = 12'h200, CL = 12'h400,
        MA = 12'h800;
    typedef struct packed {
        logic [2:0] kind;
        logic halt;
        logic [8:0] exp;
    } dsec_row_type;
    logic clk, resetn, halt_mode_cfg, external_break_flag;
    logic external_debug_request, fetch_valid, fetch_bp_hit, data_valid;
    logic data_wp_hit, pipe_advance, flush_branch, flush_exception;
    logic exec_valid, instr_complete, cp_busy_wait, mem_abort;
    logic exception_pending, irq_in, scan_instr_valid, debug_restart;
    logic [dsec_pkg::MODE_W-1:0] exception_mode, current_mode, debug_entry_mode;
    logic [1:0] core_htrans, abort_source, htrans;
    logic [dsec_pkg::INSTR_W-1:0] scan_instr, inject_instr;
    logic debug_state_ack, core_halt, exec_cancel, instr_abort, data_abort;
    logic block_updates, cp_terminate, refetch_req, irq_out, abort_out;
    logic inject_valid, flag_fetch, flag_data, req_go, clr;
    logic [8:0] seen;
    int mismatches, n_checks;
    dsec_row_type rows [10];
    dsec_top dut (.clk(clk), .resetn(resetn), .halt_mode_cfg(halt_mode_cfg),
        .external_break_flag(external_break_flag),
        .external_debug_request(external_debug_request),
        .fetch_valid(fetch_valid), .fetch_bp_hit(fetch_bp_hit),
        .data_valid(data_valid), .data_wp_hit(data_wp_hit),
        .pipe_advance(pipe_advance), .flush_branch(flush_branch),
        .flush_exception(flush_exception), .exec_valid(exec_valid),
        .instr_complete(instr_complete), .cp_busy_wait(cp_busy_wait),
        .mem_abort(mem_abort), .exception_pending(exception_pending),
        .exception_mode(exception_mode), .current_mode(current_mode),
        .irq_in(irq_in), .core_htrans(core_htrans),
        .scan_instr_valid(scan_instr_valid), .scan_instr(scan_instr),
        .debug_restart(debug_restart), .debug_state_ack(debug_state_ack),
        .core_halt(core_halt), .exec_cancel(exec_cancel),
        .instr_abort(instr_abort), .data_abort(data_abort),
        .abort_source(abort_source), .block_updates(block_updates),
        .cp_terminate(cp_terminate), .refetch_req(refetch_req),
        .debug_entry_mode(debug_entry_mode), .htrans(htrans),
        .irq_out(irq_out), .abort_out(abort_out),
        .inject_valid(inject_valid), .inject_instr(inject_instr));
    dsec_break_agent partner (.clk(clk), .resetn(resetn),
        .fetch_valid(fetch_valid), .data_valid(data_valid),
        .flag_fetch(flag_fetch), .flag_data(flag_data), .req_go(req_go),
        .debug_state_ack(debug_state_ack),
        .external_break_flag(external_break_flag),
        .external_debug_request(external_debug_request));
    // ****************************************************************
    // Clock, output monitor, tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (clr) begin
            seen <= 9'h000;
        end else begin
            seen <= seen | {abort_out, inject_valid, cp_terminate,
                block_updates, refetch_req, exec_cancel, data_abort,
                instr_abort, debug_state_ack};
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic drv(input logic [11:0] p);
        @(posedge clk);
        {mem_abort, clr, scan_instr_valid, debug_restart, instr_complete,
            flush_exception, flush_branch, pipe_advance, data_wp_hit,
            data_valid, fetch_bp_hit, fetch_valid} <= p;
    endtask
    task automatic idle(input int n);
        repeat (n) drv(12'h000);
    endtask
    task automatic run(input logic [2:0] kind, input logic halt,
        input logic [11:0] fl);
        halt_mode_cfg <= halt;
        flag_fetch <= (kind == 3'd2);
        flag_data <= (kind == 3'd3);
        req_go <= (kind == 3'd4);
        if (kind == 3'd0 || kind == 3'd2) begin
            drv(FV | CL | ((kind == 3'd0) ? BP : 12'h000));
            drv(ADV);
            drv(fl);
            idle(1);
            drv(ADV);
            drv(ADV);
        end else if (kind == 3'd1 || kind == 3'd3) begin
            drv(DV | CL | ((kind == 3'd1) ? WP : 12'h000));
            idle(5);
            drv(IC);
        end else begin
            drv(CL);
            idle(4);
            drv(IC);
        end
        req_go <= 1'b0;
        flag_fetch <= 1'b0;
        flag_data <= 1'b0;
        idle(8);
        if (seen[0] === 1'b1) begin
            drv(RS);
            idle(3);
        end
    endtask
    initial begin
        #(25 * 5000);
        mismatches++;
        close_out();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {resetn, halt_mode_cfg, fetch_valid, fetch_bp_hit, data_valid} = 5'h00;
        {data_wp_hit, pipe_advance, flush_branch, flush_exception} = 4'h0;
        {exec_valid, instr_complete, cp_busy_wait, mem_abort} = 4'h0;
        {exception_pending, irq_in, scan_instr_valid, debug_restart} = 4'h0;
        {flag_fetch, flag_data, req_go, clr} = 4'h0;
        {exception_mode, current_mode, core_htrans} = 12'h000;
        scan_instr = 32'h0000_0000;
        mismatches = 0;
        n_checks = 0;
        rows = '{'{3'd0, 1'b1, 9'h019}, '{3'd1, 1'b1, 9'h011},
            '{3'd2, 1'b1, 9'h019}, '{3'd3, 1'b1, 9'h011},
            '{3'd4, 1'b1, 9'h011}, '{3'd0, 1'b0, 9'h00A},
            '{3'd1, 1'b0, 9'h004}, '{3'd2, 1'b0, 9'h00A},
            '{3'd3, 1'b0, 9'h004}, '{3'd4, 1'b0, 9'h000}};
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        exec_valid <= 1'b1;
        core_htrans <= 2'h2;
        current_mode <= 5'h13;
        idle(3);
        check({debug_state_ack, exec_cancel, instr_abort, data_abort,
            abort_source, refetch_req, htrans}, 32'h2);
        for (int i = 0; i < 10; i++) begin
            run(rows[i].kind, rows[i].halt, 12'h000);
            check(seen, rows[i].exp);
            if (!rows[i].halt && rows[i].kind != 3'd4)
                check(abort_source, rows[i].kind[0] ?
                    dsec_pkg::ABORT_SRC_WATCH : dsec_pkg::ABORT_SRC_BREAK);
        end
        // Flushes cancel a flag, refetch flags again
        run(3'd0, 1'b1, FB);
        check(seen, 32'h0);
        run(3'd0, 1'b1, FE);
        check(seen, 32'h0);
        run(3'd0, 1'b1, 12'h000);
        check(seen, 32'h19);
        // Long transfer: entry waits, mode locked
        exception_pending <= 1'b1;
        exception_mode <= 5'h11;
        halt_mode_cfg <= 1'b1;
        drv(DV | WP | CL);
        idle(1);
        halt_mode_cfg <= 1'b0;
        idle(5);
        check(seen, 32'h0);
        drv(IC);
        idle(3);
        check(seen[0], 32'h1);
        check(debug_entry_mode, 32'h11);
        // Debug state: serial injection, events masked
        irq_in <= 1'b1;
        scan_instr <= 32'hA5A5_0F0F;
        drv(SV | MA);
        idle(2);
        check(seen[7], 32'h1);
        check(inject_instr, 32'hA5A5_0F0F);
        check({seen[8], irq_out, htrans}, 32'h0);
        drv(RS);
        idle(3);
        check({irq_out, htrans}, 32'h6);
        // Genuine memory abort in monitor mode
        irq_in <= 1'b0;
        exception_pending <= 1'b0;
        drv(MA | CL);
        idle(3);
        check(seen & 9'h120, 32'h120);
        check(abort_source, dsec_pkg::ABORT_SRC_MEMORY);
        // Request during a coprocessor busy wait
        halt_mode_cfg <= 1'b1;
        cp_busy_wait <= 1'b1;
        req_go <= 1'b1;
        drv(CL);
        idle(7);
        check(seen & 9'h041, 32'h41);
        check(external_debug_request, 32'h0);
        // Reset while in debug state
        resetn <= 1'b0;
        cp_busy_wait <= 1'b0;
        req_go <= 1'b0;
        idle(2);
        check({debug_state_ack, core_halt, htrans}, 32'h0);
        resetn <= 1'b1;
        idle(2);
        close_out();
    end
endmodule
`default_nettype wire
